// *** rtl/flash_psc_defines.svh ***
// Constants for the program and suspend command sequencer.
`ifndef FLASH_PSC_DEFINES_SVH
`define FLASH_PSC_DEFINES_SVH

// ================================================================
// Opcodes
`define OP_WRITE_ENABLE_COMMAND        8'h06
`define OP_QPP4        8'h34
`define OP_DPP         8'hD2
`define OP_SUSP_A      8'hB0
`define OP_SUSP_B      8'h75
`define OP_RES_A       8'h30
`define OP_RES_B       8'h7A

// ================================================================
// Frame layout
`define OPCODE_EDGES   4'h8
`define ADDR_BYTES_3   3'h3
`define ADDR_BYTES_4   3'h4
`define PAGE_FULL      9'h100
`define SECTOR_LSB     12

// ================================================================
// Timing
`define CLK_SYS_PERIOD_NS 40
`define SETTLE_NS      28000
`define RES_MIN_NS     300
`define SETTLE_CYC     (`SETTLE_NS / `CLK_SYS_PERIOD_NS)
`define RES_MIN_CYC    ((`RES_MIN_NS + `CLK_SYS_PERIOD_NS - 1) / `CLK_SYS_PERIOD_NS)

`endif

// *** rtl/flash_psc_pkg.sv ***
// Types for the program and suspend command sequencer.
package flash_psc_pkg;

    // ================================================================
    // Self-timed program cycle states, Gray coded along idle, run, suspended.
    typedef enum logic [1:0] {
        P_IDLE = 2'b00,
        P_RUN  = 2'b01,
        P_SUSP = 2'b11
    } prog_state_e;

endpackage : flash_psc_pkg

// *** rtl/flash_program_suspend_control.sv ***
// Command sequencer for quad and double-rate page program with write suspend and resume.
`include "flash_psc_defines.svh"

module flash_program_suspend_control #(
    parameter int unsigned PROG_CYCLES = 1000
) (
    input  wire logic                          clk_sys_i,
    input  wire logic                          rst_i,
    input  wire logic                          sclk_i,
    input  wire logic                          cs_n_i,
    input  wire logic                          io_line_0_i,
    input  wire logic                          io_line_1_i,
    input  wire logic                          io_line_2_i,
    input  wire logic                          io_line_3_i,
    input  wire logic                          quad_io_enable_bit_i,
    input  wire logic                          addr_4byte_i,
    input  wire logic                          protect_hit_i,
    input  wire logic                          erase_busy_i,
    input  wire logic                          chip_erase_busy_i,
    input  wire logic [31:0]                   erase_addr_i,
    input  wire logic [7:0]                    buf_rd_idx_i,
    output logic                               write_in_progress_flag_o,
    output logic                               write_enable_latch_o,
    output logic                               erase_suspended_flag_o,
    output logic                               program_suspended_flag_o,
    output logic                               prog_start_o,
    output logic                               prog_done_o,
    output logic [31:0]                        prog_addr_o,
    output logic [8:0]                         prog_count_o,
    output logic [31:0]                        cand_addr_o,
    output logic [7:0]                         buf_rd_data_o,
    output logic                               buf_rd_mask_o
);
    import flash_psc_pkg::*;

    // ================================================================
    // Link side, rising edge: opcode and nibble capture
    logic        in_frame;
    logic [7:0]  op;
    logic [3:0]  rise_cnt;
    logic [3:0]  nib;
    logic [3:0]  prev_nib;
    logic        half;
    logic        nib_valid;
    logic        a4_m;
    logic        a4_s;
    logic        lock_m;
    logic        lock_s;
    logic        buf_lock;
    logic [3:0]  io_now;

    assign io_now = {io_line_3_i, io_line_2_i, io_line_1_i, io_line_0_i};

    // The link clock stops between frames, so the frame flag is ended by chip select itself.
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    always_ff @(posedge sclk_i) begin
        a4_m   <= addr_4byte_i;
        a4_s   <= a4_m;
        lock_m <= buf_lock;
        lock_s <= lock_m;
    end

    // Counters keep their values after the frame so the system side can read them.
    always_ff @(posedge sclk_i) begin
        if (!in_frame) begin
            op        <= {7'h00, io_line_0_i};
            rise_cnt  <= 4'h1;
            nib_valid <= 1'b0;
            half      <= 1'b0;
        end else if (rise_cnt != `OPCODE_EDGES) begin
            op       <= {op[6:0], io_line_0_i};
            rise_cnt <= rise_cnt + 4'h1;
        end else begin
            nib       <= io_now;
            prev_nib  <= nib;
            half      <= ~half;
            nib_valid <= 1'b1;
        end
    end

    // ================================================================
    // Link side, falling edge: byte assembly and page buffer
    logic         ddr_l;
    logic         is_prog_l;
    logic [2:0]   addr_len;
    logic [2:0]   addr_cnt;
    logic [31:0]  addr;
    logic [7:0]   data_off;
    logic [8:0]   data_cnt;
    logic [255:0] mask;
    logic [7:0]   page [0:255];
    logic         take;
    logic [7:0]   byte_in;
    logic [7:0]   wr_idx;
    logic         data_phase;

    assign ddr_l      = (op == `OP_DPP);
    assign is_prog_l  = ddr_l || (op == `OP_QPP4);
    assign addr_len   = ((op == `OP_QPP4) || a4_s) ? `ADDR_BYTES_4 : `ADDR_BYTES_3;
    assign take       = nib_valid && (ddr_l || !half) && is_prog_l && !lock_s;
    assign byte_in    = ddr_l ? {nib, io_now} : {prev_nib, nib};
    assign wr_idx     = addr[7:0] + data_off;
    assign data_phase = (addr_cnt == addr_len);

    // Writes are blocked while a cycle owns the buffer, including a suspended one.
    always_ff @(negedge sclk_i) begin
        if ((rise_cnt == `OPCODE_EDGES) && !nib_valid) begin
            addr_cnt <= 3'h0;
            addr     <= 32'h0000_0000;
            data_off <= 8'h00;
            data_cnt <= 9'h000;
            if (is_prog_l && !lock_s) begin
                mask <= '0;
            end
        end else if (take) begin
            if (!data_phase) begin
                addr     <= {addr[23:0], byte_in};
                addr_cnt <= addr_cnt + 3'h1;
            end else begin
                mask[wr_idx] <= 1'b1;
                data_off     <= data_off + 8'h01;
                if (data_cnt != `PAGE_FULL) begin
                    data_cnt <= data_cnt + 9'h001;
                end
            end
        end
    end

    // Later bytes overwrite earlier ones at the same page slot.
    always_ff @(negedge sclk_i) begin
        if (take && data_phase) begin
            page[wr_idx] <= byte_in;
        end
    end

    // ================================================================
    // System side: chip select crossing and decode strobe
    logic        cs_m;
    logic        cs_s;
    logic        cs_d;
    logic        dec;
    logic        single_ok;
    logic        prog_frame_ok;

    // Link registers are static while chip select is high, so they are read directly here.
    assign single_ok     = (rise_cnt == `OPCODE_EDGES) && !nib_valid;
    assign prog_frame_ok = (rise_cnt == `OPCODE_EDGES) && data_phase
                           && (data_cnt != 9'h000) && (ddr_l || !half);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cs_m        <= 1'b1;
            cs_s        <= 1'b1;
            cs_d        <= 1'b1;
            dec         <= 1'b0;
            cand_addr_o <= 32'h0000_0000;
        end else begin
            cs_m <= cs_n_i;
            cs_s <= cs_m;
            cs_d <= cs_s;
            dec  <= cs_s && !cs_d;
            if (cs_s && !cs_d) begin
                cand_addr_o <= addr;
            end
        end
    end

    // ================================================================
    // Command qualification
    prog_state_e pstate;
    logic [31:0] timer;
    logic [9:0]  settle;
    logic [3:0]  guard;
    logic        quiet;
    logic        erase_live;
    logic        susp_go;
    logic        res_go;
    logic        write_enable_command_go;
    logic        qe_ok;
    logic        prog_go;
    logic        sector_hit;

    assign quiet      = (settle == 10'h000);
    assign erase_live = erase_busy_i && !erase_suspended_flag_o;
    assign sector_hit = erase_suspended_flag_o
                        && (cand_addr_o[31:`SECTOR_LSB] == erase_addr_i[31:`SECTOR_LSB]);
    assign qe_ok      = (op == `OP_QPP4) ? quad_io_enable_bit_i : ddr_l;

    assign susp_go = dec && single_ok && ((op == `OP_SUSP_A) || (op == `OP_SUSP_B)) && quiet
                     && (guard == 4'h0)
                     && !program_suspended_flag_o && !erase_suspended_flag_o
                     && ((pstate == P_RUN) || (erase_live && !chip_erase_busy_i));

    assign res_go = dec && single_ok && ((op == `OP_RES_A) || (op == `OP_RES_B)) && quiet
                    && (program_suspended_flag_o || erase_suspended_flag_o);

    assign write_enable_command_go = dec && single_ok && (op == `OP_WRITE_ENABLE_COMMAND) && quiet && !write_in_progress_flag_o;

    assign prog_go = dec && prog_frame_ok && qe_ok
                     && write_enable_latch_o
                     && quiet && (pstate == P_IDLE) && !erase_live
                     && !protect_hit_i
                     && !sector_hit;

    // ================================================================
    // Self-timed program cycle
    // The remaining count freezes while suspended, so the total run time stays fixed.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pstate       <= P_IDLE;
            timer        <= 32'h0000_0000;
            prog_start_o <= 1'b0;
            prog_done_o  <= 1'b0;
            prog_addr_o  <= 32'h0000_0000;
            prog_count_o <= 9'h000;
        end else begin
            prog_start_o <= 1'b0;
            prog_done_o  <= 1'b0;
            case (pstate)
                P_IDLE: begin
                    if (prog_go) begin
                        pstate       <= P_RUN;
                        timer        <= 32'(PROG_CYCLES);
                        prog_start_o <= 1'b1;
                        prog_addr_o  <= cand_addr_o;
                        prog_count_o <= data_cnt;
                    end
                end
                P_RUN: begin
                    if (susp_go) begin
                        pstate <= P_SUSP;
                    end else if (timer <= 32'h0000_0001) begin
                        pstate      <= P_IDLE;
                        prog_done_o <= 1'b1;
                    end else begin
                        timer <= timer - 32'h0000_0001;
                    end
                end
                P_SUSP: begin
                    if (res_go) begin
                        pstate <= P_RUN;
                    end
                end
                default: begin
                    pstate <= P_IDLE;
                end
            endcase
        end
    end

    // ================================================================
    // Latches and suspend flags
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            write_enable_latch_o <= 1'b0;
        end else if (prog_go) begin
            write_enable_latch_o <= 1'b0;
        end else if (write_enable_command_go) begin
            write_enable_latch_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            program_suspended_flag_o <= 1'b0;
            erase_suspended_flag_o   <= 1'b0;
        end else if (susp_go) begin
            program_suspended_flag_o <= (pstate == P_RUN);
            erase_suspended_flag_o   <= (pstate != P_RUN);
        end else if (res_go) begin
            program_suspended_flag_o <= 1'b0;
            erase_suspended_flag_o   <= 1'b0;
        end
    end

    // ================================================================
    // Suspend latency and resume spacing
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            settle <= 10'h000;
        end else if (susp_go) begin
            settle <= 10'(`SETTLE_CYC);
        end else if (!quiet) begin
            settle <= settle - 10'h001;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            guard <= 4'h0;
        end else if (res_go) begin
            guard <= 4'(`RES_MIN_CYC);
        end else if (guard != 4'h0) begin
            guard <= guard - 4'h1;
        end
    end

    // ================================================================
    // Status and buffer read port
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            write_in_progress_flag_o <= 1'b0;
            buf_lock                 <= 1'b0;
        end else begin
            write_in_progress_flag_o <= (pstate == P_RUN) || !quiet || erase_live;
            buf_lock                 <= (pstate != P_IDLE) || prog_go;
        end
    end

    // The array engine reads the page only while the buffer is locked, when it cannot change.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            buf_rd_data_o <= 8'h00;
            buf_rd_mask_o <= 1'b0;
        end else begin
            buf_rd_data_o <= page[buf_rd_idx_i];
            buf_rd_mask_o <= mask[buf_rd_idx_i];
        end
    end

endmodule : flash_program_suspend_control

// *** verif/flash_host_model.sv ***
// Host controller model that drives the quad serial link.
module flash_host_model (
    output logic       sclk_o,
    output logic       cs_n_o,
    output logic [3:0] io_o
);
    timeunit 1ns;
    timeprecision 10ps;

    logic [7:0] q[$];

    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        io_o = 4'h0;
    end

    // ========
    // Link edges
    // Data moves while the clock is low for rising samples and while high for falling samples.
    task automatic ph(input logic [3:0] v, input bit lvl);
        io_o = v;
        #3.75 sclk_o = lvl;
        #3.75;
    endtask : ph

    task automatic frame(input logic [7:0] op, input bit ddr, input bit odd);
        cs_n_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            ph({3'h0, op[i]}, 1'b1);
            ph({3'h0, op[i]}, 1'b0);
        end
        foreach (q[i]) begin
            ph(q[i][7:4], 1'b1);
            if (!ddr) ph(q[i][7:4], 1'b0);
            ph(q[i][3:0], !ddr);
            if (!ddr) ph(q[i][3:0], 1'b0);
        end
        if (odd) begin
            ph(4'hF, 1'b1);
            ph(4'hF, 1'b0);
        end
        #3.75 cs_n_o = 1'b1;
        // Released lines show the inverse so a stale value is never mistaken for data.
        io_o = ~io_o;
    endtask : frame

endmodule : flash_host_model

// *** verif/flash_psc_props.sv ***
// Port checker of the program and suspend sequencer.
module flash_psc_props #(
    parameter int unsigned PROG_CYCLES = 1000
) (
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    input wire logic       cs_n_i,
    input wire logic       chip_erase_busy_i,
    input wire logic       write_in_progress_flag_o,
    input wire logic       write_enable_latch_o,
    input wire logic       erase_suspended_flag_o,
    input wire logic       program_suspended_flag_o,
    input wire logic       prog_start_o,
    input wire logic       prog_done_o,
    input wire logic [8:0] prog_count_o
);
    default clocking dc @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    // ========
    // Running time, frozen while suspended.
    logic [15:0] run_cnt;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || prog_start_o) begin
            run_cnt <= 16'h0000;
        end else if (write_in_progress_flag_o && !program_suspended_flag_o) begin
            run_cnt <= run_cnt + 16'h0001;
        end
    end

    // ========
    // Assertions
    start_wel_a: assert property (prog_start_o |-> !write_enable_latch_o)
        else $error("latch set at program start");
    start_busy_a: assert property (prog_start_o |=> write_in_progress_flag_o)
        else $error("busy missing after start");
    done_idle_a: assert property (prog_done_o |=> !write_in_progress_flag_o)
        else $error("busy stuck after done");
    start_cs_a: assert property (prog_start_o |-> $past(cs_n_i, 3))
        else $error("start while selected");
    count_range_a: assert property (prog_start_o |-> prog_count_o inside {[9'h001:9'h100]})
        else $error("count out of range");
    one_susp_a: assert property (!(erase_suspended_flag_o && program_suspended_flag_o))
        else $error("two writes suspended");
    susp_settle_a: assert property ($rose(program_suspended_flag_o) |-> write_in_progress_flag_o [*8])
        else $error("busy dropped in settle");
    chip_skip_a: assert property ($rose(erase_suspended_flag_o) |-> !$past(chip_erase_busy_i))
        else $error("chip erase suspended");
    start_free_a: assert property (prog_start_o |-> !$past(program_suspended_flag_o))
        else $error("start while suspended");
    run_limit_a: assert property (prog_done_o |-> run_cnt <= PROG_CYCLES + 2)
        else $error("program ran too long");

    cover property (prog_start_o);
    cover property ($rose(program_suspended_flag_o));
    cover property ($rose(erase_suspended_flag_o));

endmodule : flash_psc_props

bind flash_program_suspend_control flash_psc_props #(.PROG_CYCLES(PROG_CYCLES)) flash_psc_props_i (
    .clk_sys_i, .rst_i, .cs_n_i, .chip_erase_busy_i, .write_in_progress_flag_o, .write_enable_latch_o,
    .erase_suspended_flag_o, .program_suspended_flag_o, .prog_start_o, .prog_done_o, .prog_count_o);

// *** verif/tb_flash_program_suspend_control.sv ***
// Self-checking bench of the program and suspend sequencer.
module tb_flash_program_suspend_control;
    timeunit 1ns;
    timeprecision 10ps;

    localparam int unsigned PROG_CYCLES = 40;
    typedef struct packed {
        logic [7:0] op;
        logic [4:0] fl;
        logic [8:0] nb;
        logic [8:0] cnt;
    } row_s;

    logic        clk_sys_i, rst_i, sclk_i, cs_n_i;
    logic        quad_io_enable_bit_i, addr_4byte_i, protect_hit_i, erase_busy_i, chip_erase_busy_i;
    logic        write_in_progress_flag_o, write_enable_latch_o, erase_suspended_flag_o;
    logic        program_suspended_flag_o, prog_start_o, prog_done_o, buf_rd_mask_o;
    logic [3:0]  io;
    logic [7:0]  buf_rd_idx_i, buf_rd_data_o;
    logic [8:0]  prog_count_o;
    logic [31:0] erase_addr_i, prog_addr_o, cand_addr_o;
    int          n_mismatch, samples_checked, n_start, n_done;

    // Flags: address mode, quad enable, write enable first, protected, odd nibble.
    row_s rows[8] = '{
        {8'h34, 5'h0C, 9'h003, 9'h003},
        {8'h34, 5'h08, 9'h003, 9'h000},
        {8'h34, 5'h04, 9'h003, 9'h000},
        {8'h34, 5'h0E, 9'h003, 9'h000},
        {8'h34, 5'h0D, 9'h002, 9'h000},
        {8'h34, 5'h0C, 9'h000, 9'h000},
        {8'hD2, 5'h0C, 9'h004, 9'h004},
        {8'hD2, 5'h1C, 9'h005, 9'h005}
    };

    flash_host_model flash_host_model_i (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .io_o(io));
    flash_program_suspend_control #(.PROG_CYCLES(PROG_CYCLES)) flash_program_suspend_control_i (
        .clk_sys_i, .rst_i, .sclk_i, .cs_n_i, .io_line_0_i(io[0]), .io_line_1_i(io[1]),
        .io_line_2_i(io[2]), .io_line_3_i(io[3]), .quad_io_enable_bit_i, .addr_4byte_i, .protect_hit_i,
        .erase_busy_i, .chip_erase_busy_i, .erase_addr_i, .buf_rd_idx_i, .write_in_progress_flag_o,
        .write_enable_latch_o, .erase_suspended_flag_o, .program_suspended_flag_o, .prog_start_o,
        .prog_done_o, .prog_addr_o, .prog_count_o, .cand_addr_o, .buf_rd_data_o, .buf_rd_mask_o);

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    // Pulses last one cycle, so they are counted rather than polled.
    always @(negedge clk_sys_i) begin
        n_start += int'(prog_start_o === 1'b1);
        n_done += int'(prog_done_o === 1'b1);
    end

    // ========
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic send(input logic [7:0] op, input logic [31:0] a, input int na, input int nb, input bit odd);
        logic [8:0] n;
        flash_host_model_i.q.delete();
        for (int i = na - 1; i >= 0; i--) begin
            flash_host_model_i.q.push_back(a[8*i+:8]);
        end
        for (int i = 0; i < nb; i++) begin
            n = 9'(i);
            flash_host_model_i.q.push_back({n[8], n[6:0]});
        end
        flash_host_model_i.frame(op, op == 8'hD2, odd);
        repeat (8) @(negedge clk_sys_i);
    endtask : send

    task automatic wait_idle();
        for (int i = 0; i < 200 && write_in_progress_flag_o !== 1'b0; i++) begin
            @(negedge clk_sys_i);
        end
        chk(write_in_progress_flag_o, 0);
    endtask : wait_idle

    task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic m);
        buf_rd_idx_i = idx;
        repeat (2) @(negedge clk_sys_i);
        if (m) chk(buf_rd_data_o, d);
        chk(buf_rd_mask_o, m);
    endtask : rd

    // ========
    // Sequence
    initial begin
        int s;
        rst_i = 1'b1;
        {quad_io_enable_bit_i, addr_4byte_i, protect_hit_i, erase_busy_i, chip_erase_busy_i} = 5'h00;
        erase_addr_i = 32'h00003000;
        buf_rd_idx_i = 8'h00;
        repeat (12) @(negedge clk_sys_i);
        rst_i = 1'b0;
        chk({write_in_progress_flag_o, write_enable_latch_o, erase_suspended_flag_o, program_suspended_flag_o}, 0);
        repeat (4) @(negedge clk_sys_i);
        foreach (rows[i]) begin
            {addr_4byte_i, quad_io_enable_bit_i, protect_hit_i} = {rows[i].fl[4:3], rows[i].fl[1]};
            if (rows[i].fl[2]) begin
                send(8'h06, 0, 0, 0, 0);
                chk(write_enable_latch_o, 1);
            end
            s = n_start;
            send(rows[i].op, 32'h00010210, (rows[i].op == 8'h34 || rows[i].fl[4]) ? 4 : 3, rows[i].nb, rows[i].fl[0]);
            chk(n_start - s, rows[i].cnt != 0);
            if (rows[i].cnt != 0) begin
                chk(prog_count_o, rows[i].cnt);
                chk(prog_addr_o, 32'h00010210);
                chk(write_enable_latch_o, 0);
                wait_idle();
            end
        end
        send(8'h06, 0, 0, 0, 0);
        send(8'h34, 32'h000102F8, 4, 258, 0);
        chk(prog_count_o, 9'h100);
        rd(8'hF8, 8'h80, 1);
        rd(8'hFA, 8'h02, 1);
        wait_idle();
        send(8'h06, 0, 0, 0, 0);
        send(8'h34, 32'h000102F8, 4, 10, 0);
        rd(8'h01, 8'h09, 1);
        rd(8'h02, 8'h00, 0);
        wait_idle();
        send(8'h06, 0, 0, 0, 0);
        send(8'h34, 32'h00020000, 4, 1, 0);
        s = n_done;
        send(8'hB0, 0, 0, 0, 0);
        chk({program_suspended_flag_o, write_in_progress_flag_o}, 2'b11);
        send(8'h7A, 0, 0, 0, 0);
        chk(program_suspended_flag_o, 1);
        repeat (720) @(negedge clk_sys_i);
        // A live erase makes the second suspend tempting, so the one-suspend guard is really exercised.
        erase_busy_i = 1'b1;
        send(8'h75, 0, 0, 0, 0);
        chk({erase_suspended_flag_o, program_suspended_flag_o}, 2'b01);
        erase_busy_i = 1'b0;
        send(8'h30, 0, 0, 0, 0);
        chk(program_suspended_flag_o, 0);
        wait_idle();
        chk(n_done - s, 1);
        erase_busy_i = 1'b1;
        send(8'h75, 0, 0, 0, 0);
        chk(erase_suspended_flag_o, 1);
        repeat (720) @(negedge clk_sys_i);
        s = n_start;
        send(8'h06, 0, 0, 0, 0);
        send(8'h34, 32'h00003010, 4, 1, 0);
        chk(n_start - s, 0);
        chk(cand_addr_o, 32'h00003010);
        send(8'h34, 32'h00005010, 4, 1, 0);
        chk(n_start - s, 1);
        wait_idle();
        send(8'h7A, 0, 0, 0, 0);
        chk(erase_suspended_flag_o, 0);
        chip_erase_busy_i = 1'b1;
        repeat (20) @(negedge clk_sys_i);
        send(8'h75, 0, 0, 0, 0);
        chk(erase_suspended_flag_o, 0);
        // Reset in mid-run clears the flags, and the still running erase shows as busy again.
        rst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        chk({write_in_progress_flag_o, write_enable_latch_o, erase_suspended_flag_o, program_suspended_flag_o}, 0);
        rst_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        chk(write_in_progress_flag_o, 1);
        final_report();
    end

    initial begin
        repeat (40000) @(posedge clk_sys_i);
        n_mismatch++;
        final_report();
    end

endmodule : tb_flash_program_suspend_control
